/* logic/dtx_pkg.sv */
// Constants, encodings and state types shared by the tone transceiver files.
`default_nettype none
package dtx_pkg;

  // The system clock stands in for the free-running crystal; all timing derives from it.
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned CRYSTAL_HZ = 3_579_545;

  // Avalon byte offsets of the two register words.
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFS_DATA = 4'h0;
  localparam logic [3:0] OFS_CTRL = 4'h4;

  // Control register A fields.
  localparam int CRA_TONE_OUT_ENABLE = 0;
  localparam int CRA_PROGRESS_MODE_SELECT = 1;
  localparam int CRA_IRQ_ENABLE = 2;
  localparam int CRA_CTRL_B_SELECT = 3;
  // Control register B fields.
  localparam int CRB_BURST = 0;
  localparam int CRB_TEST = 1;
  localparam int CRB_SINGLE = 2;
  localparam int CRB_COLUMN = 3;
  // Status register fields.
  localparam int ST_IRQ = 0;
  localparam int ST_TX_READY = 1;
  localparam int ST_RX_FULL = 2;
  localparam int ST_STEER = 3;

  localparam logic [3:0] CRA_RESET = 4'h0;
  localparam logic [3:0] CRB_RESET = 4'h0;
  localparam logic [3:0] CODE_RESET = 4'h0;

  // Burst and pause timing; progress mode doubles both.
  localparam int unsigned BURST_MS = 51;
  localparam int unsigned BURST_CYC = CLK_HZ / 1000 * BURST_MS;
  localparam int unsigned PROGRESS_BURST_FACTOR = 2;

  // Receiver guard times, digital stand-ins for the external steering RC.
  localparam int unsigned PRESENT_GUARD_US = 20_000;
  localparam int unsigned ABSENT_GUARD_US = 20_000;
  localparam int unsigned PRESENT_GUARD_CYC = CLK_HZ / 1_000_000 * PRESENT_GUARD_US;
  localparam int unsigned ABSENT_GUARD_CYC = CLK_HZ / 1_000_000 * ABSENT_GUARD_US;
  localparam int TIMER_W = 25;

  // Tone synthesis.
  localparam int TONE_SEGMENTS = 32;
  localparam int SEG_W = 14;
  localparam int unsigned ROW_HZ [4] = '{697, 770, 852, 941};
  localparam int unsigned COL_HZ [4] = '{1209, 1336, 1477, 1633};

  typedef enum logic [1:0] {BURST_IDLE, BURST_TONE, BURST_PAUSE} dtx_burst_st_t;
  typedef enum logic [1:0] {RX_ABSENT, RX_QUALIFY, RX_PRESENT, RX_DROPOUT} dtx_rx_st_t;

  // Segment length in clocks minus one, rounded to nearest.
  function automatic logic [SEG_W-1:0] dtx_seg_len(input int unsigned hz);
    int unsigned div;
    div = (CLK_HZ + hz * TONE_SEGMENTS / 2) / (hz * TONE_SEGMENTS);
    return SEG_W'(div - 1);
  endfunction : dtx_seg_len

  // Digit code to two-of-eight: column one-hot in [7:4], row one-hot in [3:0].
  function automatic logic [7:0] dtx_two_of_eight(input logic [3:0] code);
    logic [7:0] r;
    r = 8'h00;
    case (code)
      4'h1: r = 8'h11;
      4'h2: r = 8'h21;
      4'h3: r = 8'h41;
      4'h4: r = 8'h12;
      4'h5: r = 8'h22;
      4'h6: r = 8'h42;
      4'h7: r = 8'h14;
      4'h8: r = 8'h24;
      4'h9: r = 8'h44;
      4'ha: r = 8'h28;
      4'hb: r = 8'h18;
      4'hc: r = 8'h48;
      4'hd: r = 8'h81;
      4'he: r = 8'h82;
      4'hf: r = 8'h84;
      default: r = 8'h88;
    endcase
    return r;
  endfunction : dtx_two_of_eight

endpackage : dtx_pkg
`default_nettype wire

/* logic/dtx_tone_channel.sv */
// One tone channel: segment divider, 32-step phase counter and sine table.
`timescale 1ns/1ps
`default_nettype none
module dtx_tone_channel import dtx_pkg::*; #(
  parameter int SEG_BITS = SEG_W
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [SEG_BITS-1:0] seg_len_i,
  output logic signed [7:0] sample_o
);

  typedef struct packed {
    logic [SEG_BITS-1:0] seg_cnt;
    logic [4:0] phase;
    logic signed [7:0] sample;
  } dtx_chan_t;

  dtx_chan_t s;
  dtx_chan_t next_s;

  // Quarter-wave table, amplitude 127; the rest is folded by symmetry.
  function automatic logic signed [7:0] dtx_sine(input logic [4:0] ph);
    logic [3:0] a;
    logic signed [7:0] q;
    a = (ph[3:0] <= 4'h8) ? ph[3:0] : 4'h0 - ph[3:0];
    case (a)
      4'h0: q = 8'sh00;
      4'h1: q = 8'sh19;
      4'h2: q = 8'sh31;
      4'h3: q = 8'sh47;
      4'h4: q = 8'sh5a;
      4'h5: q = 8'sh6a;
      4'h6: q = 8'sh75;
      4'h7: q = 8'sh7d;
      default: q = 8'sh7f;
    endcase
    return ph[4] ? -q : q;
  endfunction : dtx_sine

  always_comb begin
    next_s = s;
    // The divider restarts when it reaches the count chosen by the code.
    if (s.seg_cnt >= seg_len_i) begin
      next_s.seg_cnt = '0;
      next_s.phase = s.phase + 5'h01;
    end else begin
      next_s.seg_cnt = s.seg_cnt + SEG_BITS'(1);
    end
    next_s.sample = dtx_sine(s.phase);
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sample_o = s.sample;

endmodule : dtx_tone_channel
`default_nettype wire

/* logic/dtx_transceiver.sv */
// Digital core of the tone transceiver: register port, tone generator, burst timer, receiver.
//
// Our own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - All tones and timers run from one free-running clock.
// - Transmit code uses the same four-bit encoding the receiver reports.
// - Row tone is 697, 770, 852 or 941 Hz.
// - Column tone is 1209, 1336, 1477 or 1633 Hz.
// - Codes 1-9 are digits, 10 is zero, then star, hash, A-C; 0 is D.
// - Transmit write latches the code and turns it into a two-of-eight selection.
// - A tone period is 32 segments; divider restarts at its coded count.
// - Divider steps a phase counter into a sine table; row and column summed.
// - Tone generators never stop, so bursts start without delay.
// - Burst mode gives 51 ms tone then 51 ms pause.
// - After burst and pause the transmitter-ready status bit is set.
// - Progress mode with burst doubles both intervals to 102 ms.
// - Progress mode with burst transmits but never decodes received tones.
// - Single-tone mode outputs only the selected row or column tone.
// - A tone shorter than recognition time leaves receive data unchanged.
// - After validated absence the receive data holds until the next valid tone.
// - A dropout shorter than the absent guard keeps the tone and data.
// - Status bit 3 shows the delayed steering condition.
// - Status bit 2 sets on new receive data and clears on status read.
// - Interrupt asserts on new receive data outside progress mode and releases on status read.
// - Select and direction decode to tx write, rx read, control write, status read.
// - Control A bit 0 enables the tone output, burst or not.
// - Outside progress mode, interrupt pin pulls low on new data or, in burst, transmitter ready.
// - Control A bit 3 steers only the next control write to control B.
module dtx_transceiver import dtx_pkg::*; #(
  parameter int unsigned BURST_CYCLES = BURST_CYC,
  parameter int unsigned PRESENT_GUARD_CYCLES = PRESENT_GUARD_CYC,
  parameter int unsigned ABSENT_GUARD_CYCLES = ABSENT_GUARD_CYC
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic early_tone_detect_i,
  input wire logic [3:0] rx_code_i,
  input wire logic progress_tone_i,
  output logic steer_in_guard_out_o,
  output logic signed [8:0] tone_sample_o,
  output logic tone_active_o,
  output logic test_mode_o,
  output logic irq_or_progress_out_o,
  output logic irq_or_progress_out_oe_o
);

  typedef struct packed {
    logic done;
    logic [31:0] rdata;
    logic [3:0] tx_code;
    logic [7:0] two_of_eight;
    logic [3:0] control_reg_a;
    logic [3:0] control_reg_b;
    logic b_pending;
    dtx_burst_st_t bst;
    logic [TIMER_W-1:0] btimer;
    logic tx_ready;
    logic irq_flag;
    dtx_rx_st_t rst;
    logic [TIMER_W-1:0] rtimer;
    logic [3:0] rx_data;
    logic rx_full;
    logic steer;
    logic signed [8:0] sample;
    logic tone_on;
  } dtx_state_t;

  localparam logic [TIMER_W-1:0] BURST_LAST = TIMER_W'(BURST_CYCLES - 1);
  localparam logic [TIMER_W-1:0] PROGRESS_LAST =
    TIMER_W'(BURST_CYCLES * PROGRESS_BURST_FACTOR - 1);
  localparam logic [TIMER_W-1:0] PRESENT_LAST = TIMER_W'(PRESENT_GUARD_CYCLES - 1);
  localparam logic [TIMER_W-1:0] ABSENT_LAST = TIMER_W'(ABSENT_GUARD_CYCLES - 1);

  dtx_state_t s;
  dtx_state_t next_s;

  logic [SEG_W-1:0] row_len;
  logic [SEG_W-1:0] col_len;
  logic signed [7:0] row_sample;
  logic signed [7:0] col_sample;
  logic req;
  logic take;
  logic status_rd;
  logic burst_mode;
  logic progress_mode;
  logic rx_enable;
  logic [TIMER_W-1:0] burst_last;
  logic rx_event;
  logic ready_event;
  logic [3:0] status;

  // The two-of-eight code selects one divider setting per group.
  always_comb begin
    row_len = '0;
    col_len = '0;
    for (int i = 0; i < 4; i++) begin
      if (s.two_of_eight[i]) begin
        row_len = row_len | dtx_seg_len(ROW_HZ[i]);
      end
      if (s.two_of_eight[4+i]) begin
        col_len = col_len | dtx_seg_len(COL_HZ[i]);
      end
    end
  end

  // Status word assembled from the field positions so software sees one fixed layout.
  always_comb begin
    status = 4'h0;
    status[ST_IRQ] = s.irq_flag;
    status[ST_TX_READY] = s.tx_ready;
    status[ST_RX_FULL] = s.rx_full;
    status[ST_STEER] = s.steer;
  end

  // Both channels free-run from reset; gating only chooses what reaches the output.
  dtx_tone_channel #(.SEG_BITS(SEG_W)) u_row (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .seg_len_i(row_len),
    .sample_o(row_sample)
  );

  dtx_tone_channel #(.SEG_BITS(SEG_W)) u_col (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .seg_len_i(col_len),
    .sample_o(col_sample)
  );

  assign req = avs_read_i | avs_write_i;
  assign take = req & ~s.done;
  assign status_rd = take & avs_read_i & (avs_address_i == OFS_CTRL);
  assign burst_mode = s.control_reg_b[CRB_BURST];
  assign progress_mode = s.control_reg_a[CRA_PROGRESS_MODE_SELECT];
  // Decoding is only switched off when both progress and burst are chosen.
  assign rx_enable = ~(progress_mode & burst_mode);
  assign burst_last = progress_mode ? PROGRESS_LAST : BURST_LAST;

  always_comb begin
    next_s = s;
    rx_event = 1'b0;
    ready_event = 1'b0;

    // Bus: accept in the first cycle of a request, answer one cycle later.
    next_s.done = take;
    if (take && avs_read_i) begin
      case (avs_address_i)
        OFS_DATA: next_s.rdata = {28'h0000000, s.rx_data};
        OFS_CTRL: next_s.rdata = {28'h0000000, status};
        default: next_s.rdata = 32'h00000000;
      endcase
    end

    // Burst timer: tone, then pause of equal length, then ready.
    case (s.bst)
      BURST_TONE: begin
        if (s.btimer >= burst_last) begin
          next_s.bst = BURST_PAUSE;
          next_s.btimer = '0;
        end else begin
          next_s.btimer = s.btimer + TIMER_W'(1);
        end
      end
      BURST_PAUSE: begin
        if (s.btimer >= burst_last) begin
          next_s.bst = BURST_IDLE;
          next_s.btimer = '0;
          ready_event = 1'b1;
        end else begin
          next_s.btimer = s.btimer + TIMER_W'(1);
        end
      end
      default: begin
        next_s.btimer = '0;
      end
    endcase
    if (!burst_mode) begin
      // Without burst mode the host times the tone through the enable bit.
      next_s.bst = BURST_IDLE;
      next_s.btimer = '0;
    end

    // Status read clears the sticky flags; an event in the same cycle wins below.
    if (status_rd) begin
      next_s.rx_full = 1'b0;
      next_s.irq_flag = 1'b0;
      next_s.tx_ready = 1'b0;
    end

    if (take && avs_write_i && avs_byteenable_i[0]) begin
      if (avs_address_i == OFS_DATA) begin
        next_s.tx_code = avs_writedata_i[3:0];
        next_s.two_of_eight = dtx_two_of_eight(avs_writedata_i[3:0]);
        if (burst_mode && s.bst == BURST_IDLE) begin
          next_s.bst = BURST_TONE;
          next_s.btimer = '0;
          next_s.tx_ready = 1'b0;
        end
      end else if (avs_address_i == OFS_CTRL) begin
        if (s.b_pending) begin
          next_s.control_reg_b = avs_writedata_i[3:0];
          next_s.b_pending = 1'b0;
        end else begin
          next_s.control_reg_a = avs_writedata_i[3:0];
          next_s.b_pending = avs_writedata_i[CRA_CTRL_B_SELECT];
        end
      end
    end

    // Receiver steering: digital guard timers in place of the RC network.
    case (s.rst)
      RX_QUALIFY: begin
        if (!early_tone_detect_i) begin
          next_s.rst = RX_ABSENT;
        end else if (s.rtimer >= PRESENT_LAST) begin
          next_s.rst = RX_PRESENT;
          next_s.rx_data = rx_code_i;
          next_s.steer = 1'b1;
          rx_event = 1'b1;
        end else begin
          next_s.rtimer = s.rtimer + TIMER_W'(1);
        end
      end
      RX_PRESENT: begin
        if (!early_tone_detect_i) begin
          next_s.rst = RX_DROPOUT;
          next_s.rtimer = '0;
        end
      end
      RX_DROPOUT: begin
        if (early_tone_detect_i) begin
          next_s.rst = RX_PRESENT;
        end else if (s.rtimer >= ABSENT_LAST) begin
          next_s.rst = RX_ABSENT;
          next_s.steer = 1'b0;
        end else begin
          next_s.rtimer = s.rtimer + TIMER_W'(1);
        end
      end
      default: begin
        next_s.rtimer = '0;
        if (early_tone_detect_i) begin
          next_s.rst = RX_QUALIFY;
        end
      end
    endcase
    if (!rx_enable) begin
      next_s.rst = RX_ABSENT;
      next_s.rtimer = '0;
      next_s.steer = 1'b0;
      rx_event = 1'b0;
    end

    // Sticky flags: a set in the same cycle as a status read must survive.
    if (rx_event) begin
      next_s.rx_full = 1'b1;
    end
    if (ready_event) begin
      next_s.tx_ready = 1'b1;
    end
    if (!progress_mode && (rx_event || (ready_event && burst_mode))) begin
      next_s.irq_flag = 1'b1;
    end

    // Output gating; the channels keep running so a burst edge is exact.
    next_s.tone_on = s.control_reg_a[CRA_TONE_OUT_ENABLE] & (~burst_mode | s.bst == BURST_TONE);
    if (!next_s.tone_on) begin
      next_s.sample = 9'sh000;
    end else if (s.control_reg_b[CRB_SINGLE]) begin
      next_s.sample = s.control_reg_b[CRB_COLUMN] ? 9'(col_sample) : 9'(row_sample);
    end else begin
      next_s.sample = 9'(row_sample) + 9'(col_sample);
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s <= '0;
      s.tx_code <= CODE_RESET;
      s.two_of_eight <= dtx_two_of_eight(CODE_RESET);
      s.control_reg_a <= CRA_RESET;
      s.control_reg_b <= CRB_RESET;
      s.bst <= BURST_IDLE;
      s.rst <= RX_ABSENT;
    end else begin
      s <= next_s;
    end
  end

  assign avs_waitrequest_o = take;
  assign avs_readdata_o = s.rdata;
  assign steer_in_guard_out_o = (s.rst == RX_PRESENT) | (s.rst == RX_DROPOUT);
  assign tone_sample_o = s.sample;
  assign tone_active_o = s.tone_on;
  assign test_mode_o = s.control_reg_b[CRB_TEST];
  // Open drain: the pin is only ever pulled low.  In progress mode it follows the comparator.
  assign irq_or_progress_out_o = 1'b0;
  assign irq_or_progress_out_oe_o = s.control_reg_a[CRA_IRQ_ENABLE] &
    (progress_mode ? ~progress_tone_i : s.irq_flag);

endmodule : dtx_transceiver
`default_nettype wire

/* bench/dtx_chk.sv */
// Concurrent checks on the transceiver ports.
`timescale 1ns/1ps
`default_nettype none
module dtx_chk import dtx_pkg::*; (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic early_tone_detect_i,
  input wire logic steer_in_guard_out_o,
  input wire logic signed [8:0] tone_sample_o,
  input wire logic tone_active_o,
  input wire logic irq_or_progress_out_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  sequence s_req;
    avs_read_i || avs_write_i;
  endsequence
  sequence s_held;
    steer_in_guard_out_o [*8];
  endsequence
  chk_wait_first: assert property ((avs_read_i || avs_write_i) &&
    !$past(avs_read_i || avs_write_i) |-> avs_waitrequest_o) else $error("no wait cycle");
  chk_wait_one: assert property (s_req ##0 avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("wait longer than one cycle");
  chk_read_upper: assert property (avs_read_i && !avs_waitrequest_o |->
    avs_readdata_o[31:4] == 28'h0000000) else $error("upper read bits set");
  chk_unmapped_zero: assert property (avs_read_i && !avs_waitrequest_o &&
    avs_address_i != OFS_DATA && avs_address_i != OFS_CTRL |-> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  chk_steer_guard: assert property ($rose(steer_in_guard_out_o) |->
    $past(early_tone_detect_i) && $past(early_tone_detect_i, 8)) else $error("steer too early");
  chk_dropout_hold: assert property ($fell(early_tone_detect_i) && steer_in_guard_out_o |=>
    s_held) else $error("steer lost in dropout");
  chk_tone_gate: assert property (!tone_active_o [*3] |-> tone_sample_o == 9'sh000)
    else $error("tone while gated");
  chk_od_level: assert property (irq_or_progress_out_o == 1'b0)
    else $error("open drain drives high");
endmodule : dtx_chk
bind dtx_transceiver dtx_chk u_chk (
  .clk_i(clk_i),
  .srst_i(srst_i),
  .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o),
  .early_tone_detect_i(early_tone_detect_i),
  .steer_in_guard_out_o(steer_in_guard_out_o),
  .tone_sample_o(tone_sample_o),
  .tone_active_o(tone_active_o),
  .irq_or_progress_out_o(irq_or_progress_out_o)
);
`default_nettype wire

/* bench/dtx_host.sv */
// Host processor model driving the Avalon register port.
`timescale 1ns/1ps
`default_nettype none
module dtx_host import dtx_pkg::*; (
  input wire logic clk_i,
  input wire logic [31:0] avs_readdata_i,
  input wire logic avs_waitrequest_i,
  output logic [ADDR_W-1:0] avs_address_o,
  output logic avs_read_o,
  output logic avs_write_o,
  output logic [31:0] avs_writedata_o,
  output logic [3:0] avs_byteenable_o
);
  initial begin
    avs_address_o = 4'h0;
    avs_read_o = 1'b0;
    avs_write_o = 1'b0;
    avs_writedata_o = 32'h0;
    avs_byteenable_o = 4'hf;
  end
  // The request holds until an edge sees waitrequest low; released data is inverted.
  task automatic xfer(input logic rw, input logic [3:0] a, input logic [3:0] d,
                      input logic [3:0] be, output logic [3:0] q);
    @(posedge clk_i);
    avs_address_o <= a;
    avs_writedata_o <= {28'h0000000, d};
    avs_byteenable_o <= be;
    avs_read_o <= rw;
    avs_write_o <= !rw;
    do @(posedge clk_i); while (avs_waitrequest_i !== 1'b0);
    q = avs_readdata_i[3:0];
    avs_read_o <= 1'b0;
    avs_write_o <= 1'b0;
    avs_writedata_o <= ~avs_writedata_o;
  endtask : xfer
endmodule : dtx_host
`default_nettype wire

/* bench/tb.sv */
// Self-checking bench for the tone transceiver.
`timescale 1ns/1ps
`default_nettype none
module tb import dtx_pkg::*; ();
  localparam int unsigned BURST_SIM = 50;
  logic clk, srst, det, ptone, wreq, rdm, wrm, act, steer, od, oe, tmode;
  logic [3:0] code, addr, be;
  logic [31:0] wdata, rdata;
  logic signed [8:0] smp;
  int miscompares, checks, cyc, seed;
  dtx_host h (.clk_i(clk), .avs_readdata_i(rdata), .avs_waitrequest_i(wreq),
    .avs_address_o(addr), .avs_read_o(rdm), .avs_write_o(wrm), .avs_writedata_o(wdata),
    .avs_byteenable_o(be));
  dtx_transceiver #(.BURST_CYCLES(BURST_SIM), .PRESENT_GUARD_CYCLES(20),
    .ABSENT_GUARD_CYCLES(20)) dut (.clk_i(clk), .srst_i(srst), .avs_address_i(addr),
    .avs_read_i(rdm), .avs_write_i(wrm), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .early_tone_detect_i(det),
    .rx_code_i(code), .progress_tone_i(ptone), .steer_in_guard_out_o(steer),
    .tone_sample_o(smp), .tone_active_o(act), .test_mode_o(tmode),
    .irq_or_progress_out_o(od), .irq_or_progress_out_oe_o(oe));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic int f_burst(input logic cp);
    return cp ? BURST_SIM * PROGRESS_BURST_FACTOR : BURST_SIM;
  endfunction : f_burst
  // Clocks per tone segment, with margin for rounding.
  function automatic int f_seg(input int unsigned hz);
    return CLK_HZ / (TONE_SEGMENTS * hz) + 2;
  endfunction : f_seg
  task automatic stop_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [3:0] a, output logic [3:0] q);
    h.xfer(1'b1, a, 4'h0, 4'hf, q);
  endtask : rd
  task automatic wr(input logic [3:0] a, input logic [3:0] d);
    logic [3:0] q;
    h.xfer(1'b0, a, d, 4'hf, q);
  endtask : wr
  task automatic drive(input logic v, input logic [3:0] c, input int n);
    @(posedge clk);
    det <= v;
    code <= c;
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : drive
  task automatic meas(input int exp);
    int n;
    n = 0;
    while (act !== 1'b1 && n < 10) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (act === 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    checks++;
    if (n != exp) begin
      miscompares++;
      $display("unexpected at %0t: burst of %0d cycles", $time, n);
    end
  endtask : meas
  always @(posedge clk) begin
    ptone <= 1'($random(seed));
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      stop_test();
    end
  end
  initial begin
    logic [3:0] q, c, r;
    int n;
    srst = 1'b1;
    det = 1'b0;
    code = 4'h0;
    seed = 32'h5532;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    rd(OFS_CTRL, q); chk(q, 4'h0);
    rd(OFS_DATA, q); chk(q, CODE_RESET);
    rd(4'h8, q); chk(q, 4'h0);
    wr(OFS_CTRL, 4'h4);
    r = 4'($random(seed));
    for (int i = 0; i < 16; i++) begin
      c = 4'(i) ^ r;
      drive(1'b1, c, 30);
      chk({3'h0, oe}, 4'h1);
      rd(OFS_CTRL, q); chk(q & 4'hc, 4'hc);
      chk({3'h0, oe}, 4'h0);
      rd(OFS_CTRL, q); chk(q & 4'hc, 4'h8);
      rd(OFS_DATA, q); chk(q, c);
      drive(1'b0, ~c, 30);
      rd(OFS_CTRL, q); chk(q & 4'h8, 4'h0);
      rd(OFS_DATA, q); chk(q, c);
    end
    drive(1'b1, ~c, 10);
    drive(1'b0, 4'h2, 30);
    rd(OFS_DATA, q); chk(q, c);
    drive(1'b1, 4'h6, 30);
    rd(OFS_CTRL, q);
    drive(1'b0, 4'h9, 5);
    chk({3'h0, steer}, 4'h1);
    drive(1'b1, 4'h9, 30);
    rd(OFS_CTRL, q); chk(q & 4'hc, 4'h8);
    rd(OFS_DATA, q); chk(q, 4'h6);
    drive(1'b0, 4'h3, 30);
    wr(OFS_CTRL, 4'hb);
    wr(OFS_CTRL, 4'h1);
    wr(OFS_DATA, 4'h3);
    meas(f_burst(1'b1));
    drive(1'b1, 4'h7, 30);
    drive(1'b0, 4'h8, 130);
    rd(OFS_DATA, q); chk(q, 4'h6);
    rd(OFS_CTRL, q); chk(q & 4'h4, 4'h0);
    wr(OFS_CTRL, 4'h5);
    rd(OFS_CTRL, q);
    wr(OFS_DATA, 4'h1);
    meas(f_burst(1'b0));
    repeat (40) @(negedge clk);
    chk({3'h0, oe}, 4'h0);
    rd(OFS_CTRL, q); chk(q & 4'h2, 4'h0);
    repeat (20) @(negedge clk);
    chk({3'h0, oe}, 4'h1);
    rd(OFS_CTRL, q); chk(q & 4'h2, 4'h2);
    rd(OFS_CTRL, q); chk(q & 4'h2, 4'h0);
    wr(OFS_CTRL, 4'h8);
    wr(OFS_CTRL, 4'he);
    wr(OFS_CTRL, 4'h1);
    // The column channel has run since reset, so its first step comes within one segment.
    n = 0;
    while (smp === 9'sh000 && n < f_seg(COL_HZ[0])) begin
      @(negedge clk);
      n++;
    end
    chk({3'h0, act}, 4'h1);
    chk({3'h0, (smp !== 9'sh000)}, 4'h1);
    chk({3'h0, tmode}, 4'h1);
    // The row channel is still in its first segment here, so a row-only tone reads zero.
    wr(OFS_CTRL, 4'h8);
    wr(OFS_CTRL, 4'h6);
    wr(OFS_CTRL, 4'h1);
    repeat (4) @(negedge clk);
    chk({3'h0, act}, 4'h1);
    chk({3'h0, (smp === 9'sh000)}, 4'h1);
    h.xfer(1'b0, OFS_CTRL, 4'h0, 4'h0, q);
    repeat (4) @(negedge clk);
    chk({3'h0, act}, 4'h1);
    wr(OFS_CTRL, 4'h0);
    repeat (4) @(negedge clk);
    chk({3'h0, act}, 4'h0);
    stop_test();
  end
endmodule : tb
`default_nettype wire
